// ===== rtl/mcs_params.svh
// offsets, field positions, codes and reset values of the carrier select block
// Overview of operation
// R1: high select 0-3: low, pin one, two, clock
// R2: codes 4-7 route pwm units, pwm mode only
// R3: codes 8-15 connect no source
// R4: low select decodes like high select
// R5: high invert bit flips high carrier
// R6: low invert bit flips low carrier
// R7: high sync waits high falling edge
// R8: no high sync switches to low at once
// R9: low sync waits low falling edge
// R10: no low sync switches to high at once
// R11: high release bit frees source pin drive
// R12: low release bit frees source pin drive
// R13: bit 4 reads zero, ignores writes; the code leaves it unknown from power up until the first write
// R14: carrier bits unknown at power, kept on reset
// R15: modulator one uses high, zero uses low
// R16: enable clear means no output; reset clears
// R17: output follows chosen conditioned carrier, with holds
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
// register byte offsets
`define MCS_OFF_HCAR    32'h0000_0000
`define MCS_OFF_LCAR    32'h0000_0004
`define MCS_OFF_CTRL    32'h0000_0008
`define MCS_OFF_SRC     32'h0000_000c
// write masks and reset value
`define MCS_CAR_MASK    8'hef
`define MCS_SRC_MASK    8'h8f
`define MCS_CTRL_WMASK  8'hf1
`define MCS_CTRL_RST    8'h20
// carrier register fields
`define MCS_BIT_RELEASE 7
`define MCS_BIT_INVERT  6
`define MCS_BIT_SYNC    5
`define MCS_BIT_ZERO    4
`define MCS_SEL_RSV     3
// modulator control fields
`define MCS_CTRL_EN     7
`define MCS_CTRL_OE     6
`define MCS_CTRL_SLR    5
`define MCS_CTRL_OPOL   4
`define MCS_CTRL_OUT    3
`define MCS_CTRL_SOFT   0
// carrier source codes
`define MCS_CODE_LOW    3'h0
`define MCS_CODE_PIN1   3'h1
`define MCS_CODE_PIN2   3'h2
`define MCS_CODE_REFCLK 3'h3
`define MCS_CODE_PWM1   3'h4
`define MCS_PWM_N       4
// modulator source codes
`define MCS_MSRC_SOFT   4'h0
`define MCS_MSRC_PIN    4'h1
`define MCS_MSRC_PWM1   4'h2
`define MCS_MSRC_EXT0   4'h6
`define MCS_MSRC_EXT_N  5
// carrier indices
`define MCS_HIGH        0
`define MCS_LOW         1
// bus answers
`define MCS_RESP_OKAY   2'h0
`define MCS_RESP_DECERR 2'h3
`endif

// ===== rtl/mcs_pkg.sv
// types and shared decode of the carrier select block
package mcs_pkg;
    // which carrier currently feeds the mixer, one-hot
    typedef enum logic [1:0] {
        MCS_ST_HIGH = 2'b01,
        MCS_ST_LOW  = 2'b10
    } mcs_state_t;

    // one-hot decode of a 4-bit source code
    function automatic logic [15:0] mcs_onehot(input logic [3:0] code);
        mcs_onehot = 16'h0001 << code;
    endfunction : mcs_onehot
endpackage : mcs_pkg

// ===== rtl/mcs_carrier_cond.sv
// one carrier path: source pick, inversion and source pin release
`include "mcs_params.svh"
module mcs_carrier_cond
    import mcs_pkg::*;
(
    // configuration
    input  wire logic [7:0] ctrl,
    // candidate sources, bit 0 is the constant low
    input  wire logic [7:0] sources,
    // selected source before and after inversion
    output logic            raw,
    output logic            cond,
    // per-code release of the source peripheral pin
    output logic [7:0]      release_vec
);
    logic [15:0] code_hot;  // decoded select field

    assign code_hot = mcs_onehot(ctrl[3:0]);

    // reserved codes leave the path low; bit 0 of sources is tied low
    always_comb begin
        raw = 1'b0;
        if (!ctrl[`MCS_SEL_RSV]) begin
            raw = sources[ctrl[2:0]]; // R1 R2 R4
        end else begin
            raw = 1'b0; // R3
        end
    end

    // inversion ahead of the mixer
    assign cond = raw ^ ctrl[`MCS_BIT_INVERT]; // R5 R6

    // release only reaches a real channel, never a reserved code
    assign release_vec = ctrl[`MCS_BIT_RELEASE] ? code_hot[7:0] : 8'h00; // R11 R12
endmodule : mcs_carrier_cond

// ===== rtl/mcs_top.sv
// carrier select and mixing stage with an axi4-lite register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "mcs_params.svh"
module mcs_top
    import mcs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // axi4-lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // carrier sources
    input  wire logic        carrier_input_pin_one,
    input  wire logic        carrier_input_pin_two,
    input  wire logic        reference_clock_out,
    input  wire logic        pwm_unit_one_out,
    input  wire logic        pwm_unit_two_out,
    input  wire logic        pwm_unit_three_out,
    input  wire logic        pwm_unit_four_out,
    input  wire logic [3:0]  pwm_mode_active,
    // modulator sources
    input  wire logic        modulator_input_pin,
    input  wire logic [4:0]  mod_src_extra,
    // modulated output pin
    output logic             modulator_out,
    output logic             modulator_out_en,
    output logic             modulator_slew_limit,
    // source pin releases
    output logic [7:0]       carrier_src_pin_release,
    output logic [15:0]      mod_src_pin_release
);
    // register storage
    logic [7:0]  car_ctrl [0:1];     // high and low carrier control
    logic [7:0]  ctrl_reg;           // modulator control, writable bits
    logic [7:0]  src_reg;            // modulation source control
    // write channel bookkeeping
    logic        aw_held;            // address taken, waiting for data
    logic        w_held;             // data taken, waiting for address
    logic [31:0] aw_addr;            // captured write address
    logic [31:0] w_data;             // captured write data
    logic        w_lane0;            // byte lane 0 strobe of the write
    logic        wr_fire;            // both halves present, commit now
    // datapath
    logic [7:0]  car_src;            // candidate carrier sources
    logic [3:0]  pwm_gated;          // pwm outputs, only in pwm mode
    logic [1:0]  car_raw;            // selected carriers before invert
    logic [1:0]  car_cond;           // conditioned carriers
    logic [1:0]  cond_prev;          // conditioned carriers last cycle
    logic [1:0]  car_fall;           // falling edge on each carrier
    logic [7:0]  car_release [0:1];  // release vectors per carrier
    logic [15:0] msrc_vec;           // candidate modulator sources
    logic        mod_sig;            // selected modulator signal
    mcs_state_t  state;              // carrier in use
    mcs_state_t  next_state;         // carrier for the next cycle
    logic        next_out;           // next modulated output value
    logic        enable;             // modulator enable

    // true when a byte address hits a register word
    function automatic logic mcs_hit(input logic [31:0] addr, input logic [31:0] off);
        mcs_hit = ({addr[31:2], 2'b00} == off);
    endfunction : mcs_hit

    assign enable = ctrl_reg[`MCS_CTRL_EN];

    // write path

    // ready while that half is free and no response pends
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    // capture write address, either order with data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // capture write data and its low strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MCS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // unmapped words answer decode error and store nothing
            if (mcs_hit(aw_addr, `MCS_OFF_HCAR) || mcs_hit(aw_addr, `MCS_OFF_LCAR) ||
                mcs_hit(aw_addr, `MCS_OFF_CTRL) || mcs_hit(aw_addr, `MCS_OFF_SRC)) begin
                s_axi_bresp <= `MCS_RESP_OKAY;
            end else begin
                s_axi_bresp <= `MCS_RESP_DECERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // carrier registers have no reset: they power up unknown and
    // survive every reset, so software must load them before enabling
    always_ff @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (wr_fire && w_lane0 && mcs_hit(aw_addr, c[0] ? `MCS_OFF_LCAR : `MCS_OFF_HCAR)) begin
                car_ctrl[c] <= w_data[7:0] & `MCS_CAR_MASK; // R13 R14
            end
        end
    end

    // modulation source register, also kept across reset
    always_ff @(posedge clock) begin
        if (wr_fire && w_lane0 && mcs_hit(aw_addr, `MCS_OFF_SRC)) begin
            src_reg <= w_data[7:0] & `MCS_SRC_MASK;
        end
    end

    // modulator control; reset disables the module
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `MCS_CTRL_RST; // R16
        end else if (wr_fire && w_lane0 && mcs_hit(aw_addr, `MCS_OFF_CTRL)) begin
            ctrl_reg <= w_data[7:0] & `MCS_CTRL_WMASK;
        end
    end

    // read path

    // one read at a time; new address only once data is gone
    assign s_axi_arready = !s_axi_rvalid;

    // read data one cycle after the address handshake
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `MCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `MCS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (mcs_hit(s_axi_araddr, `MCS_OFF_HCAR)) begin
                s_axi_rdata[7:0] <= car_ctrl[`MCS_HIGH];
            end else if (mcs_hit(s_axi_araddr, `MCS_OFF_LCAR)) begin
                s_axi_rdata[7:0] <= car_ctrl[`MCS_LOW];
            end else if (mcs_hit(s_axi_araddr, `MCS_OFF_CTRL)) begin
                // live output shows in the status bit
                s_axi_rdata[7:0] <= ctrl_reg | ({7'h00, modulator_out} << `MCS_CTRL_OUT);
            end else if (mcs_hit(s_axi_araddr, `MCS_OFF_SRC)) begin
                s_axi_rdata[7:0] <= src_reg;
            end else begin
                s_axi_rresp <= `MCS_RESP_DECERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // carrier paths

    // a pwm output counts only while its unit runs in pwm mode
    assign pwm_gated = {pwm_unit_four_out, pwm_unit_three_out,
                        pwm_unit_two_out, pwm_unit_one_out} & pwm_mode_active; // R2

    // candidate carriers in code order
    always_comb begin
        car_src = 8'h00;
        car_src[`MCS_CODE_LOW]    = 1'b0; // R1
        car_src[`MCS_CODE_PIN1]   = carrier_input_pin_one;
        car_src[`MCS_CODE_PIN2]   = carrier_input_pin_two;
        car_src[`MCS_CODE_REFCLK] = reference_clock_out;
        car_src[`MCS_CODE_PWM1 +: `MCS_PWM_N] = pwm_gated;
    end

    // both carriers share one decoder structure
    for (genvar c = 0; c < 2; c++) begin : g_car
        mcs_carrier_cond u_cond (
            .ctrl        (car_ctrl[c]),
            .sources     (car_src),
            .raw         (car_raw[c]),
            .cond        (car_cond[c]),
            .release_vec (car_release[c])
        );
    end

    // a source pin is freed if either carrier asks for it
    assign carrier_src_pin_release = car_release[`MCS_HIGH] | car_release[`MCS_LOW]; // R11 R12

    // modulator source

    // candidate modulator signals; unlisted codes stay low
    always_comb begin
        msrc_vec = 16'h0000;
        msrc_vec[`MCS_MSRC_SOFT] = ctrl_reg[`MCS_CTRL_SOFT];
        msrc_vec[`MCS_MSRC_PIN]  = modulator_input_pin;
        msrc_vec[`MCS_MSRC_PWM1 +: `MCS_PWM_N]   = pwm_gated;
        msrc_vec[`MCS_MSRC_EXT0 +: `MCS_MSRC_EXT_N] = mod_src_extra;
    end

    assign mod_sig = msrc_vec[src_reg[3:0]];

    // release of the modulator source pin
    assign mod_src_pin_release = src_reg[`MCS_BIT_RELEASE] ? mcs_onehot(src_reg[3:0]) : 16'h0000;

    // switching and mixing

    // edge detection needs last cycle's carriers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cond_prev <= 2'b00;
        end else begin
            cond_prev <= car_cond;
        end
    end

    assign car_fall = cond_prev & ~car_cond;

    // switching decision; a synchronised carrier holds until it falls,
    // trading a short lag for whole carrier pulses
    always_comb begin
        next_state = state;
        unique case (state)
            MCS_ST_HIGH: begin
                if (!mod_sig && (!car_ctrl[`MCS_HIGH][`MCS_BIT_SYNC] ||
                                 car_fall[`MCS_HIGH])) begin
                    next_state = MCS_ST_LOW; // R7 R8
                end
            end
            MCS_ST_LOW: begin
                if (mod_sig && (!car_ctrl[`MCS_LOW][`MCS_BIT_SYNC] ||
                                car_fall[`MCS_LOW])) begin
                    next_state = MCS_ST_HIGH; // R9 R10
                end
            end
        endcase
        // idle: track the modulator so enabling starts clean
        if (!enable) begin
            next_state = mod_sig ? MCS_ST_HIGH : MCS_ST_LOW; // R15
        end
    end

    // mixed value for the next cycle
    always_comb begin
        next_out = 1'b0;
        if (enable) begin
            next_out = ctrl_reg[`MCS_CTRL_OPOL] ^
                       ((next_state == MCS_ST_HIGH) ? car_cond[`MCS_HIGH]
                                                    : car_cond[`MCS_LOW]); // R17
        end
    end

    // carrier state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= MCS_ST_LOW;
        end else begin
            state <= next_state;
        end
    end

    // registered output; low while disabled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            modulator_out <= 1'b0; // R16
        end else begin
            modulator_out <= next_out;
        end
    end

    // pin controls straight from the control register
    assign modulator_out_en     = enable && ctrl_reg[`MCS_CTRL_OE]; // R16
    assign modulator_slew_limit = ctrl_reg[`MCS_CTRL_SLR];

    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    disabled_out_low_a: assert property (!enable |=> !modulator_out) // R16
        else $error("output active while disabled");
    bit4_zero_a: assert property (wr_fire && w_lane0 && mcs_hit(aw_addr, `MCS_OFF_HCAR)
        |=> !car_ctrl[0][4]) // R13
        else $error("carrier bit 4 not zero");
    reserved_no_src_a: assert property (car_ctrl[0][3] |-> !car_raw[0]) // R3
        else $error("reserved code drives carrier");
    const_low_src_a: assert property (car_ctrl[1][3:0] == 4'h0 |-> !car_raw[1]) // R1
        else $error("code zero not low");
    high_invert_a: assert property (enable |-> car_cond[0] == (car_raw[0] ^ car_ctrl[0][6])) // R5
        else $error("high inversion wrong");
    high_mix_a: assert property (enable && state == MCS_ST_HIGH && mod_sig
        |=> modulator_out == ($past(ctrl_reg[4]) ^ $past(car_cond[0]))) // R15
        else $error("high carrier not mixed");
    high_sync_hold_a: assert property (enable && state == MCS_ST_HIGH && !mod_sig
        && car_ctrl[0][5] && !car_fall[0] |=> state == MCS_ST_HIGH) // R7
        else $error("high sync switched early");
    high_no_sync_a: assert property (enable && state == MCS_ST_HIGH && !mod_sig
        && !car_ctrl[0][5] |=> state == MCS_ST_LOW) // R8
        else $error("high switch delayed");
    low_sync_hold_a: assert property (enable && state == MCS_ST_LOW && mod_sig
        && car_ctrl[1][5] && !car_fall[1] |=> state == MCS_ST_LOW) // R9
        else $error("low sync switched early");
    low_no_sync_a: assert property (enable && state == MCS_ST_LOW && mod_sig
        && !car_ctrl[1][5] |=> state == MCS_ST_HIGH) // R10
        else $error("low switch delayed");
    high_release_a: assert property (car_ctrl[0][7] && !car_ctrl[0][3]
        |-> carrier_src_pin_release[car_ctrl[0][2:0]]) // R11
        else $error("high source pin not released");
endmodule : mcs_top

// ===== verif/mcs_src_model.sv
// far-side carrier and modulator sources for the carrier select bench
module mcs_src_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // bench noise and settings
    input  wire logic [7:0] noise,
    input  wire logic [3:0] pwm_cfg,
    input  wire logic       slow,
    // source levels
    output logic            pin_one,
    output logic            pin_two,
    output logic            ref_clk,
    output logic [3:0]      pwm,
    output logic [3:0]      pwm_mode,
    output logic            mod_pin
);
    logic [7:0] cnt; // free phase counter
    // sources move just after the edge, like peripherals on this clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
            {pin_one, pin_two, ref_clk, pwm, pwm_mode, mod_pin} <= 12'h000;
        end else begin
            cnt      <= cnt + 8'h01;
            pin_one  <= noise[0];
            pin_two  <= cnt[2];
            ref_clk  <= ~ref_clk; // half rate clock
            pwm      <= {cnt[3] & cnt[2], cnt[1], noise[1], cnt[0] | cnt[1]};
            pwm_mode <= pwm_cfg;
            // slow mode: long modulator phases
            mod_pin  <= slow ? cnt[5] : noise[2];
        end
    end
endmodule : mcs_src_model

// ===== verif/test_mcs_top.sv
// self-checking bench of the carrier select and mixing stage
`include "mcs_params.svh"
module test_mcs_top;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset and bus
    logic        clock, reset_n;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    // sources and outputs
    logic        pin_one, pin_two, ref_clk, mod_pin, slow;
    logic [3:0]  pwm, pwm_mode, pwm_cfg;
    logic [4:0]  mod_extra;
    logic [7:0]  noise, car_rel;
    logic [15:0] mod_rel;
    logic        mod_out, mod_out_en, slew;
    // bench state
    int          fails, check_count;
    logic [31:0] x, nx;
    logic [7:0]  sh [4]; // shadow registers
    logic        exp_out, st_high, prev_ch, prev_cl, chk_mix;

    mcs_top u_mcs_top (
        .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready,
        .carrier_input_pin_one(pin_one), .carrier_input_pin_two(pin_two),
        .reference_clock_out(ref_clk), .pwm_unit_one_out(pwm[0]),
        .pwm_unit_two_out(pwm[1]), .pwm_unit_three_out(pwm[2]),
        .pwm_unit_four_out(pwm[3]), .pwm_mode_active(pwm_mode),
        .modulator_input_pin(mod_pin), .mod_src_extra(mod_extra),
        .modulator_out(mod_out), .modulator_out_en(mod_out_en),
        .modulator_slew_limit(slew), .carrier_src_pin_release(car_rel),
        .mod_src_pin_release(mod_rel)
    );
    mcs_src_model u_mcs_src_model (
        .clock, .reset_n, .noise, .pwm_cfg, .slow, .pin_one, .pin_two, .ref_clk, .pwm,
        .pwm_mode, .mod_pin
    );

    // 10 MHz clock
    initial clock = 1'b0;
    always #50 clock = ~clock;

    // xorshift step
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xorshift = t ^ (t << 5);
    endfunction : xorshift
    // expected conditioned carrier
    function automatic logic car_pick(input logic [7:0] r);
        logic [7:0] src;
        src = {pwm & pwm_mode, ref_clk, pin_two, pin_one, 1'b0};
        car_pick = (r[3] ? 1'b0 : src[r[2:0]]) ^ r[6];
    endfunction : car_pick
    // expected modulator level
    function automatic logic mod_pick(input logic [3:0] c);
        logic [15:0] src;
        src = {5'h00, mod_extra, pwm & pwm_mode, mod_pin, sh[2][0]};
        mod_pick = src[c];
    endfunction : mod_pick
    // expected pin releases
    function automatic logic [7:0] rel8(input logic on, input logic [3:0] c);
        rel8 = (on && !c[3]) ? 8'h01 << c[2:0] : 8'h00;
    endfunction : rel8

    // compare tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask : check_bit
    // verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic give_up;
        fails++;
        final_report();
    endtask : give_up

    // one write, both halves together
    task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 64) give_up();
        s_axi_bready <= 1'b0;
        check_val({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_write
    // one checked read
    task automatic rd_chk(input logic [31:0] a, e, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 64) give_up();
        check_val(s_axi_rdata, e);
        check_val({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask : rd_chk

    // source noise, own sequence
    always @(posedge clock) begin
        nx = xorshift(nx);
        noise     <= nx[7:0];
        mod_extra <= nx[12:8];
    end

    // mixer reference, one clock latency
    always @(posedge clock) begin : mix_model
        logic       ch, cl, m, nh;
        logic [1:0] wi;
        if (!reset_n) begin
            sh[2]   = `MCS_CTRL_RST;
            exp_out = 1'b0;
        end else begin
            if (chk_mix) check_bit(mod_out, exp_out);
            // shadow follows each answered write
            wi = s_axi_awaddr[3:2];
            if (s_axi_bvalid && s_axi_wstrb[0] && s_axi_awaddr[31:4] == 28'h0)
                sh[wi] = s_axi_wdata[7:0] & ((wi == 2'd2) ? `MCS_CTRL_WMASK :
                         (wi == 2'd3) ? `MCS_SRC_MASK : `MCS_CAR_MASK);
            ch = car_pick(sh[0]);
            cl = car_pick(sh[1]);
            m  = mod_pick(sh[3][3:0]);
            if (!sh[2][7]) nh = m;
            else if (st_high) nh = !(!m && (!sh[0][5] || (prev_ch && !ch)));
            else nh = m && (!sh[1][5] || (prev_cl && !cl));
            exp_out = sh[2][7] ? (sh[2][4] ^ (nh ? ch : cl)) : 1'b0;
            st_high = nh;
            prev_ch = ch;
            prev_cl = cl;
        end
    end

    // main sequence
    initial begin : main
        int         i;
        logic [7:0] v;
        {x, nx} = {32'h1, 32'h1};
        {chk_mix, st_high, prev_ch, prev_cl, slow, reset_n} = 6'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {s_axi_wstrb, pwm_cfg, noise, mod_extra} = 21'h0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rd_chk(`MCS_OFF_CTRL, 32'h20, `MCS_RESP_OKAY);
        check_bit(slew, 1'b1);
        // readback, bit 4 and upper bits stay zero
        for (i = 0; i < 8; i++) begin
            x = xorshift(x);
            axi_write(i[0] ? `MCS_OFF_LCAR : `MCS_OFF_HCAR, x, 4'hf, `MCS_RESP_OKAY);
            rd_chk(i[0] ? `MCS_OFF_LCAR : `MCS_OFF_HCAR, {24'h0, x[7:0] & 8'hef}, 2'h0);
        end
        // strobe off stores nothing, unmapped word refused
        axi_write(`MCS_OFF_LCAR, ~x, 4'h0, `MCS_RESP_OKAY);
        rd_chk(`MCS_OFF_LCAR, {24'h0, x[7:0] & 8'hef}, `MCS_RESP_OKAY);
        axi_write(32'h10, x, 4'hf, `MCS_RESP_DECERR);
        rd_chk(32'h10, 32'h0, `MCS_RESP_DECERR);
        // all select codes, release on and off
        for (i = 0; i < 32; i++) begin
            axi_write(`MCS_OFF_HCAR, {24'h0, i[4], 3'h0, i[3:0]}, 4'hf, `MCS_RESP_OKAY);
            axi_write(`MCS_OFF_LCAR, {24'h0, ~i[4], 3'h0, 4'hf - i[3:0]}, 4'hf, 2'h0);
            axi_write(`MCS_OFF_SRC, {24'h0, i[4], 3'h0, i[3:0]}, 4'hf, `MCS_RESP_OKAY);
            check_val({24'h0, car_rel}, {24'h0, rel8(i[4], i[3:0]) | rel8(~i[4], 4'hf - i[3:0])});
            check_val({16'h0, mod_rel}, {16'h0, i[4] ? 16'h1 << i[3:0] : 16'h0});
        end
        // output enable and slew bits
        for (i = 0; i < 4; i++) begin
            v = {i[1], i[0], i[0] ^ i[1], 5'h00};
            axi_write(`MCS_OFF_CTRL, {24'h0, v}, 4'hf, `MCS_RESP_OKAY);
            check_bit(mod_out_en, i[1] & i[0]);
            check_bit(slew, v[5]);
        end
        axi_write(`MCS_OFF_CTRL, 32'h20, 4'hf, `MCS_RESP_OKAY);
        repeat (2) @(posedge clock);
        chk_mix = 1'b1;
        // mixing sweep, all high codes
        for (i = 0; i < 16; i++) begin
            x = xorshift(x);
            slow    <= i[0];
            pwm_cfg <= x[3:0];
            axi_write(`MCS_OFF_CTRL, {24'h0, 3'b001, x[4], 3'h0, x[5]}, 4'hf, 2'h0);
            axi_write(`MCS_OFF_HCAR, {24'h0, x[6], x[7], x[8], 1'b0, i[3:0]}, 4'hf, 2'h0);
            axi_write(`MCS_OFF_LCAR, {24'h0, x[9], x[10], x[11], 1'b0, 4'hf - i[3:0]}, 4'hf, 2'h0);
            v = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h01 : 8'h06 + {6'h0, i[1:0]};
            axi_write(`MCS_OFF_SRC, {24'h0, v}, 4'hf, `MCS_RESP_OKAY);
            axi_write(`MCS_OFF_CTRL, {24'h0, 3'b101, x[4], 3'h0, x[5]}, 4'hf, 2'h0);
            repeat (60) @(posedge clock);
        end
        // mid-run reset keeps carriers, clears enable
        axi_write(`MCS_OFF_HCAR, 32'hc5, 4'hf, `MCS_RESP_OKAY);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd_chk(`MCS_OFF_HCAR, 32'hc5, `MCS_RESP_OKAY);
        rd_chk(`MCS_OFF_CTRL, 32'h20, `MCS_RESP_OKAY);
        repeat (10) @(posedge clock);
        final_report();
    end
endmodule : test_mcs_top
